// ### shared/idept_pkg.sv
// Constants, field layouts and carrier types for the IDE PIO decode and timing block
//
// Overview of operation
// [R1] Decode only when I/O space and channel enabled
// [R2] 8-byte command, 4-byte control range, upper zero
// [R3] Primary command 01F0h, control 03F4h
// [R4] Secondary command 0170h, control 0374h
// [R5] Access asserts block select, runs compatible strobe
// [R6] Data port sixteen bits, others eight bits
// [R7] Control offset 03h forwarded to ISA floppy
// [R8] Claim every decoded access without byte enables
// [R9] Shadow drive-select bit per connector
// [R10] Fast timing only for data port accesses
// [R11] Drive outputs change only on clock edges
// [R12] Each drive uses its own timing mode
// [R13] Sync DMA leaves PIO timing unchanged
// [R14] Startup interval before strobe when not set up
// [R15] Fast strobe width 2 to 5 clocks
// [R16] Fast recovery 1 to 4 clocks
// [R17] Ready asserted at sample: no wait states
// [R18] Ready negated: extend strobe, two clocks minimum
// [R19] Two clock shutdown after data transactions
// [R20] Non-data compatible: startup 4, sample 11, cycle 22
// [R21] ISA recovery adds nothing when fast timing on; code suppresses it on fast reads only, fast writes still request it
// [R22] Per-drive ready masking treats ready asserted
// [R23] 32-bit data access splits into two halves
// [R24] Address lines carry low three offset bits
package idept_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [31:0] IDEPT_PRI_CMD_BASE = 32'h0000_01F0; // Primary command block
	localparam logic [31:0] IDEPT_PRI_CTL_BASE = 32'h0000_03F4; // Primary control block
	localparam logic [31:0] IDEPT_SEC_CMD_BASE = 32'h0000_0170; // Secondary command block
	localparam logic [31:0] IDEPT_SEC_CTL_BASE = 32'h0000_0374; // Secondary control block
	localparam logic [31:0] IDEPT_CMD_MASK     = 32'hFFFF_FFF8; // 8-byte range
	localparam logic [31:0] IDEPT_CTL_MASK     = 32'hFFFF_FFFC; // 4-byte range
	localparam logic [2:0]  IDEPT_OFS_DATA     = 3'h0;          // Data register
	localparam logic [2:0]  IDEPT_OFS_DRVHEAD  = 3'h6;          // Drive/head register
	localparam logic [2:0]  IDEPT_OFS_FLOPPY   = 3'h3;          // Control byte forwarded to ISA
	localparam int          IDEPT_DRV_BIT      = 4;             // Drive select bit position

	// ----------------------------------------------------------------
	// Timing counts in PCI clocks
	// ----------------------------------------------------------------
	localparam logic [4:0] IDEPT_ND_STARTUP   = 5'h04; // Non-data startup
	localparam logic [4:0] IDEPT_ND_ISP       = 5'h0B; // Non-data ready sample point
	localparam logic [4:0] IDEPT_ND_RCT       = 5'h16; // Non-data cycle time
	localparam logic [4:0] IDEPT_DC_STARTUP   = 5'h03; // Data compatible startup
	localparam logic [4:0] IDEPT_DC_ISP       = 5'h06; // Data compatible sample point
	localparam logic [4:0] IDEPT_DC_RCT       = 5'h0E; // Data compatible cycle time
	localparam logic [4:0] IDEPT_FT_STARTUP   = 5'h02; // Fast timing startup
	localparam logic [4:0] IDEPT_SHUTDOWN     = 5'h02; // Shutdown hold
	localparam logic [4:0] IDEPT_ISP_BASE     = 5'h02; // Fast width code 0 means 2 clocks
	localparam logic [4:0] IDEPT_RCV_BASE     = 5'h01; // Fast recovery code 0 means 1 clock
	localparam logic [4:0] IDEPT_RDY_EXTRA    = 5'h02; // Least extension after late ready

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic       fast_en;   // Fast timing on data port
		logic       ready_mask; // Ignore ready input
		logic [1:0] width_code; // Strobe width, 2..5 clocks
		logic [1:0] rcv_code;   // Recovery, 1..4 clocks
	} idept_drv_timing_t;

	typedef struct packed
	{
		logic       valid;  // Request present
		logic       write;  // 1 = write
		logic [31:0] addr;  // I/O byte address
		logic [3:0] be_n;   // Byte enables, active low
		logic [31:0] wdata; // Write data
	} idept_req_t;

	typedef enum logic [5:0]
	{
		IDEPT_IDLE  = 6'b000001,
		IDEPT_SETUP = 6'b000010,
		IDEPT_STRB  = 6'b000100,
		IDEPT_WAIT  = 6'b001000,
		IDEPT_RCVR  = 6'b010000,
		IDEPT_SHUT  = 6'b100000
	} idept_state_t;

endpackage

// ### logic/idept_channel_engine.sv
// IDE PIO decode and strobe timing engine for two legacy channels
`timescale 1ns/1ps
module idept_channel_engine
	import idept_pkg::*;
(
	input  wire logic              clk,              // PCI clock, 200 MHz
	input  wire logic              resetn,           // Async reset, active low
	input  wire idept_req_t        req,              // PCI I/O request
	input  wire logic              io_space_en,      // Function command reg I/O enable
	input  wire logic [1:0]        chan_decode_en,   // Per channel decode enable
	input  wire idept_drv_timing_t drv_timing [4],   // Index chan*2+drive
	input  wire logic              isa_rcv16_en,     // ISA 16-bit recovery enable
	input  wire logic              primary_drive_ready_wait,   // Pin, async
	input  wire logic              secondary_drive_ready_wait, // Pin, async
	input  wire logic [15:0]       drive_data_in,    // Drive data bus read value
	output logic                   claim,            // DEVSEL claim pulse
	output logic                   isa_forward,      // Forward to ISA pulse
	output logic                   done,             // Transfer done pulse
	output logic [31:0]            rdata,            // Read data
	output logic [1:0]             command_block_select_n, // Per channel
	output logic [1:0]             control_block_select_n, // Per channel
	output logic [2:0]             drive_address_lines,
	output logic [1:0]             drive_read_strobe_n,    // Per channel
	output logic [1:0]             drive_write_strobe_n,   // Per channel
	output logic [15:0]            drive_data_out,
	output logic                   drive_data_oe,    // High while driving data
	output logic                   isa_recovery_wait, // Recovery stall request
	output logic [1:0]             drive_shadow      // Shadow drive bit per channel
);

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed
	{
		idept_state_t st;
		logic [4:0]  cnt;      // Interval counter
		logic [4:0]  sample;   // Clocks of late-ready extension, or gap count between halves
		logic        chan;     // Active channel
		logic        is_cmd;   // Command block selected
		logic        is_data;  // Data port access
		logic        write;
		logic        second;   // Second 16-bit half pending
		logic        half;     // Currently upper half
		logic [2:0]  ofs;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [1:0]  shadow;   // Drive bit per connector
		logic        claim;
		logic        fwd;
		logic        done;
		logic        busy_req; // Request already accepted
		logic [1:0]  rdy_s1;
		logic [1:0]  rdy_s2;
		logic        rcv_wait;
		logic [1:0]  cs_cmd_n, cs_ctl_n, rd_n, wr_n; // Registered pin images
		logic [15:0] dout;     // Registered drive data word
		logic        oe;       // Registered data enable
	} idept_st_t;

	idept_st_t cur;      // Registered state
	idept_st_t next_cur; // Next state

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic       hit_pc, hit_pt, hit_sc, hit_st; // Range hits
	logic       hit_any;
	idept_drv_timing_t tm; // Timing of selected drive
	logic       fast;      // Fast timing applies
	logic       rdy;       // Synchronised ready of active channel
	logic [4:0] startup, ready_sample_point, recovery_cycle_time;
	logic       next_live; // Selects asserted in the next cycle

	always_comb
	begin
		// Ranges only while both enables stand
		hit_pc = io_space_en && chan_decode_en[0]
			&& ((req.addr & IDEPT_CMD_MASK) == IDEPT_PRI_CMD_BASE); // R1 R2 R3
		hit_pt = io_space_en && chan_decode_en[0]
			&& ((req.addr & IDEPT_CTL_MASK) == IDEPT_PRI_CTL_BASE); // R3
		hit_sc = io_space_en && chan_decode_en[1]
			&& ((req.addr & IDEPT_CMD_MASK) == IDEPT_SEC_CMD_BASE); // R4
		hit_st = io_space_en && chan_decode_en[1]
			&& ((req.addr & IDEPT_CTL_MASK) == IDEPT_SEC_CTL_BASE); // R4
		hit_any = hit_pc | hit_pt | hit_sc | hit_st;
		// Timing picked by shadowed drive bit; sync DMA settings never enter here
		tm = drv_timing[{cur.chan, cur.shadow[cur.chan]}]; // R9 R12 R13
		fast = tm.fast_en && cur.is_data; // R10
		rdy = tm.ready_mask || cur.rdy_s2[cur.chan]; // R22
		if (fast)
		begin
			startup = IDEPT_FT_STARTUP;
			ready_sample_point = IDEPT_ISP_BASE + {3'h0, tm.width_code}; // R15
			recovery_cycle_time = ready_sample_point + IDEPT_RCV_BASE + {3'h0, tm.rcv_code}; // R16
		end
		else if (cur.is_data)
		begin
			startup = IDEPT_DC_STARTUP;
			ready_sample_point = IDEPT_DC_ISP;
			recovery_cycle_time = IDEPT_DC_RCT;
		end
		else
		begin
			startup = IDEPT_ND_STARTUP; // R20
			ready_sample_point = IDEPT_ND_ISP; // R20
			recovery_cycle_time = IDEPT_ND_RCT; // R20
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_cur = cur;
		next_cur.claim = 1'b0;
		next_cur.fwd = 1'b0;
		next_cur.done = 1'b0;
		// Two flops on each ready pin before use
		next_cur.rdy_s1 = {secondary_drive_ready_wait, primary_drive_ready_wait};
		next_cur.rdy_s2 = cur.rdy_s1;
		// Fast timing suppresses ISA recovery waits on data reads
		// Only a running drive cycle may ask for ISA recovery
		next_cur.rcv_wait = isa_rcv16_en && (cur.st != IDEPT_IDLE) && !(fast && !cur.write); // R21
		if (!req.valid)
		begin
			next_cur.busy_req = 1'b0;
		end
		case (cur.st)
			IDEPT_IDLE:
			begin
				if (req.valid && !cur.busy_req && hit_any)
				begin
					next_cur.busy_req = 1'b1;
					next_cur.claim = 1'b1; // R8
					next_cur.chan = hit_sc | hit_st;
					next_cur.is_cmd = hit_pc | hit_sc;
					next_cur.ofs = req.addr[2:0]; // R24
					next_cur.write = req.write;
					next_cur.wdata = req.wdata;
					next_cur.is_data = (hit_pc | hit_sc) && (req.addr[2:0] == IDEPT_OFS_DATA);
					// 32-bit data port access runs as two halves
					next_cur.second = next_cur.is_data && (req.be_n == 4'h0); // R23
					next_cur.half = 1'b0;
					next_cur.cnt = 5'h00;
					next_cur.sample = 5'h00;
					if (!(hit_pc | hit_sc) && req.addr[1:0] == IDEPT_OFS_FLOPPY[1:0])
					begin
						// Floppy byte goes to ISA, drive is untouched
						next_cur.fwd = 1'b1; // R7
						next_cur.done = 1'b1;
					end
					else
					begin
						next_cur.st = IDEPT_SETUP; // R14
					end
				end
			end
			IDEPT_SETUP:
			begin
				// Address and selects settle before the strobe
				next_cur.cnt = cur.cnt + 5'h01;
				if (cur.sample != 5'h00)
				begin
					// Selects stay negated between compatible halves
					next_cur.sample = cur.sample - 5'h01; // R23
					next_cur.cnt = 5'h00;
				end
				else if (cur.cnt + 5'h01 >= startup) // R14 R20
				begin
					next_cur.st = IDEPT_STRB;
					next_cur.cnt = 5'h00;
				end
			end
			IDEPT_STRB:
			begin
				next_cur.cnt = cur.cnt + 5'h01;
				if (cur.cnt + 5'h01 >= ready_sample_point)
				begin
					if (rdy)
					begin
						next_cur.st = IDEPT_RCVR; // R17
					end
					else
					begin
						next_cur.st = IDEPT_WAIT; // R18
						next_cur.sample = 5'h00;
					end
				end
			end
			IDEPT_WAIT:
			begin
				// Late ready costs at least two clocks of extension
				next_cur.sample = (cur.sample == 5'h1F) ? cur.sample : cur.sample + 5'h01;
				next_cur.cnt = cur.cnt + 5'h01;
				if (rdy && cur.sample + 5'h01 >= IDEPT_RDY_EXTRA) // R18
				begin
					next_cur.st = IDEPT_RCVR;
				end
			end
			IDEPT_RCVR:
			begin
				next_cur.cnt = cur.cnt + 5'h01;
				if (cur.cnt + 5'h01 >= recovery_cycle_time)
				begin
					next_cur.cnt = 5'h00;
					if (cur.ofs == IDEPT_OFS_DRVHEAD && cur.is_cmd && cur.write)
					begin
						next_cur.shadow[cur.chan] = cur.wdata[IDEPT_DRV_BIT]; // R9
					end
					if (cur.second && !cur.half && fast)
					begin
						// Back to back in fast mode, no shutdown
						next_cur.half = 1'b1; // R16
						next_cur.st = IDEPT_STRB;
					end
					else
					begin
						next_cur.st = IDEPT_SHUT; // R19
					end
				end
			end
			IDEPT_SHUT:
			begin
				// Hold address and selects for the shutdown interval
				next_cur.cnt = cur.cnt + 5'h01;
				if (cur.cnt + 5'h01 >= IDEPT_SHUTDOWN) // R19
				begin
					next_cur.cnt = 5'h00;
					if (cur.second && !cur.half)
					begin
						next_cur.half = 1'b1; // R23
						next_cur.sample = IDEPT_SHUTDOWN; // R23
						next_cur.st = IDEPT_SETUP;
					end
					else
					begin
						next_cur.done = 1'b1;
						next_cur.st = IDEPT_IDLE;
					end
				end
			end
			default:
			begin
				next_cur.st = IDEPT_IDLE;
			end
		endcase
		// Capture read data at strobe release
		if (cur.st inside {IDEPT_STRB, IDEPT_WAIT} && next_cur.st == IDEPT_RCVR && !cur.write)
		begin
			if (cur.half)
			begin
				next_cur.rdata[31:16] = drive_data_in; // R6
			end
			else if (cur.is_data)
			begin
				next_cur.rdata = {16'h0000, drive_data_in}; // R6
			end
			else
			begin
				next_cur.rdata = {24'h000000, drive_data_in[7:0]}; // R6
			end
		end
		// Pin images from the next state, so every drive pin leaves a flop
		next_live = (next_cur.st != IDEPT_IDLE)
			&& !(next_cur.st == IDEPT_SETUP && next_cur.sample != 5'h00); // R23
		next_cur.cs_cmd_n = 2'h3;
		next_cur.cs_ctl_n = 2'h3;
		next_cur.rd_n = 2'h3;
		next_cur.wr_n = 2'h3;
		if (next_live)
		begin
			next_cur.cs_cmd_n[next_cur.chan] = !next_cur.is_cmd; // R5
			next_cur.cs_ctl_n[next_cur.chan] = next_cur.is_cmd; // R5
			next_cur.rd_n[next_cur.chan] = !((next_cur.st inside {IDEPT_STRB, IDEPT_WAIT})
				&& !next_cur.write); // R5
			next_cur.wr_n[next_cur.chan] = !((next_cur.st inside {IDEPT_STRB, IDEPT_WAIT})
				&& next_cur.write); // R5
		end
		next_cur.dout = next_cur.half ? next_cur.wdata[31:16] : next_cur.wdata[15:0];
		next_cur.oe = next_live && next_cur.write;
	end

	// ----------------------------------------------------------------
	// State register; all drive pins leave flops
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cur <= '0;
			cur.st <= IDEPT_IDLE;
			cur.cs_cmd_n <= 2'h3;
			cur.cs_ctl_n <= 2'h3;
			cur.rd_n <= 2'h3;
			cur.wr_n <= 2'h3;
		end
		else
		begin
			cur <= next_cur; // R11
		end
	end

	logic strobing; // Strobe asserted
	assign strobing = cur.st inside {IDEPT_STRB, IDEPT_WAIT};

	// Outputs come straight from the state register
	assign command_block_select_n = cur.cs_cmd_n; // R5
	assign control_block_select_n = cur.cs_ctl_n; // R5
	assign drive_read_strobe_n = cur.rd_n; // R5
	assign drive_write_strobe_n = cur.wr_n; // R5
	assign drive_address_lines = cur.ofs; // R24
	assign drive_data_out = cur.dout;
	assign drive_data_oe = cur.oe;
	assign claim = cur.claim;
	assign isa_forward = cur.fwd;
	assign done = cur.done;
	assign rdata = cur.rdata;
	assign isa_recovery_wait = cur.rcv_wait;
	assign drive_shadow = cur.shadow;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_shut_two;
		cur.st == IDEPT_SHUT [*2];
	endsequence

	a_shutdown_two_clk: assert property (@(posedge clk) disable iff (!resetn) // R19
		$rose(cur.st == IDEPT_SHUT) |-> s_shut_two)
		else $error("shutdown shorter than two clocks");
	a_nondata_startup: assert property (@(posedge clk) disable iff (!resetn) // R20
		(cur.st == IDEPT_IDLE && next_cur.st == IDEPT_SETUP && !next_cur.is_data)
		|=> (cur.st == IDEPT_SETUP) [*4] ##1 cur.st == IDEPT_STRB)
		else $error("non-data startup not four clocks");
	a_fast_only_data: assert property (@(posedge clk) disable iff (!resetn) // R10
		!cur.is_data |-> !fast)
		else $error("fast timing on non-data register");
	a_late_ready_ext: assert property (@(posedge clk) disable iff (!resetn) // R18
		$rose(cur.st == IDEPT_WAIT) |=> cur.st == IDEPT_WAIT)
		else $error("late ready extended under two clocks");
	a_floppy_fwd: assert property (@(posedge clk) disable iff (!resetn) // R7
		cur.fwd |-> cur.st == IDEPT_IDLE && &control_block_select_n)
		else $error("floppy byte reached the drive");
	a_claim_enabled: assert property (@(posedge clk) disable iff (!resetn) // R1
		next_cur.claim |-> io_space_en)
		else $error("claim without I/O enable");
	a_strobe_selects: assert property (@(posedge clk) disable iff (!resetn) // R5
		strobing |-> !(&command_block_select_n && &control_block_select_n))
		else $error("strobe without chip select");
	a_shadow_update: assert property (@(posedge clk) disable iff (!resetn) // R9
		$changed(cur.shadow) |-> $past(cur.st) == IDEPT_RCVR && cur.ofs == IDEPT_OFS_DRVHEAD)
		else $error("shadow changed outside drive/head write");

endmodule

// ### tb/idept_drive_model.sv
// Behavioural pair of drives on each cable: ready timing and data bus
`timescale 1ns/1ps
module idept_drive_model
(
	input  wire logic        clk,      // PCI clock
	input  wire logic [1:0]  rd_n,     // Read strobes per cable
	input  wire logic [1:0]  wr_n,     // Write strobes per cable
	input  wire logic [15:0] wdata,    // Word driven by the host side
	input  wire logic        slow,     // Hold ready low after strobe start
	input  wire logic [15:0] rd_value, // Word returned on reads
	output logic [1:0]       ready,    // Ready per cable
	output logic [15:0]      rd_data,  // Data bus towards the host
	output logic [15:0]      last_wr   // Last word written
);
	// ------------------------------------------------------------
	// Strobe age and captured writes
	// ------------------------------------------------------------
	int          cnt [2];              // Cycles since strobe fell
	logic [15:0] last_bus = 16'h0000;  // Last value put on the bus
	// Age counters and write capture
	always @(posedge clk)
		for (int c = 0; c < 2; c++)
		begin
			cnt[c] <= (rd_n[c] & wr_n[c]) ? 0 : cnt[c] + 1;
			if (!wr_n[c])
				last_wr <= wdata;
			if (!rd_n[c])
				last_bus <= rd_value;
		end
	// Ready pulled up when idle; slow drive holds it low 14 clocks
	assign ready[0] = !slow || cnt[0] >= 14 || (rd_n[0] & wr_n[0]);
	assign ready[1] = !slow || cnt[1] >= 14 || (rd_n[1] & wr_n[1]);
	// Released bus shows the inverse of the last word, not a hold
	assign rd_data = (&rd_n) ? ~last_bus : rd_value;
endmodule

// ### tb/test_ide_pio_decode_timing.sv
// Self-checking bench for the IDE PIO decode and strobe timing engine
`timescale 1ns/1ps
module test_ide_pio_decode_timing
	import idept_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus and observation signals
	// ------------------------------------------------------------
	logic              clk = 1'b0;      // 200 MHz clock
	logic              resetn = 1'b0;   // Reset, active low
	idept_req_t        req = '0;        // Request to the engine
	logic              io_space_en = 1'b1;
	logic [1:0]        chan_decode_en = 2'b11;
	idept_drv_timing_t tim [4];         // Per-drive timing
	logic              isa_rcv16_en = 1'b0;
	logic              slow = 1'b0;     // Slow drive ready
	logic [15:0]       rd_value = 16'h0000;
	logic [1:0]        rdy;             // Ready pins from drives
	logic [15:0]       din;             // Drive bus to engine
	logic [15:0]       dout;            // Engine bus to drives
	logic [15:0]       last_wr;         // Captured write word
	logic              claim, isa_forward, done, oe, rwait_o;
	logic [31:0]       rdata;
	logic [1:0]        cmd_n, ctl_n, rd_n, wr_n, shadow;
	logic [2:0]        da;
	logic [31:0]       seed = 32'h0000_004E; // Xorshift state
	logic [31:0]       wdat = 32'h0000_0000; // Write data of next xfer
	logic [31:0]       exp_q [$];       // Expected read data
	logic [31:0]       msk_q [$];       // Bits that matter
	int                err_count = 0;
	int                compares = 0;
	int                nstrb, widths [2];
	logic              claimed, fwd, rwait;
	logic [2:0]        da_s;            // Address at start of last strobe
	logic [3:0]        cs_s;            // Selects at start of last strobe
	// Clock, 5 ns period
	initial
		forever #2.5 clk = ~clk;
	idept_channel_engine DUT (.clk(clk), .resetn(resetn), .req(req),
		.io_space_en(io_space_en), .chan_decode_en(chan_decode_en), .drv_timing(tim),
		.isa_rcv16_en(isa_rcv16_en), .primary_drive_ready_wait(rdy[0]),
		.secondary_drive_ready_wait(rdy[1]), .drive_data_in(din), .claim(claim),
		.isa_forward(isa_forward), .done(done), .rdata(rdata),
		.command_block_select_n(cmd_n), .control_block_select_n(ctl_n),
		.drive_address_lines(da), .drive_read_strobe_n(rd_n),
		.drive_write_strobe_n(wr_n), .drive_data_out(dout), .drive_data_oe(oe),
		.isa_recovery_wait(rwait_o), .drive_shadow(shadow));
	idept_drive_model drives (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .wdata(dout),
		.slow(slow), .rd_value(rd_value), .ready(rdy), .rd_data(din),
		.last_wr(last_wr));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One I/O cycle; counts strobes and their widths until done
	task automatic xfer(input logic [31:0] a, input logic w, input logic [3:0] be,
		input logic [31:0] msk, input logic hit);
		int   n;
		logic prev;
		nstrb = 0;
		widths = '{0, 0};
		claimed = 0;
		fwd = 0;
		rwait = 0;
		prev = 0;
		if (hit)
		begin
			exp_q.push_back({rd_value, rd_value});
			msk_q.push_back(msk);
		end
		@(negedge clk);
		req = '{1'b1, w, a, be, wdat};
		wdat = xs();
		for (n = 0; n < (hit ? 400 : 40); n++)
		begin
			@(negedge clk);
			claimed |= claim;
			fwd |= isa_forward;
			rwait |= rwait_o;
			if ((&rd_n & &wr_n) == 1'b0)
			begin
				if (!prev)
				begin
					nstrb++;
					da_s = da;
					cs_s = {ctl_n, cmd_n};
				end
				if (nstrb <= 2)
					widths[nstrb-1]++;
			end
			prev = (&rd_n & &wr_n) == 1'b0;
			if (done || isa_forward)
				break;
		end
		if (hit && n == 400)
		begin
			err_count++;
			results();
		end
		check(claimed, hit);
		@(negedge clk);
		req.valid = 1'b0;
		@(negedge clk);
	endtask
	// Result watcher: each done takes the oldest note
	always @(negedge clk)
		if (done && exp_q.size() > 0)
		begin
			check(rdata & msk_q[0], exp_q[0] & msk_q[0]);
			exp_q.pop_front();
			msk_q.pop_front();
		end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin : main
		logic [31:0] adr [4];
		logic [3:0]  cse [4];
		adr = '{32'h0000_01F7, 32'h0000_03F6, 32'h0000_0177, 32'h0000_0376};
		cse = '{4'b1110, 4'b1011, 4'b1101, 4'b0111};
		for (int i = 0; i < 4; i++)
			tim[i] = '0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		// Block map, compatible non-data reads, random byte enables
		for (int i = 0; i < 4; i++)
		begin
			rd_value = xs();
			xfer(adr[i], 1'b0, 4'(xs()), 32'h0000_00FF, 1'b1);
			check(cs_s, cse[i]);
			check(widths[0], 11);
			if (i % 2 == 0)
				check(da_s, adr[i][2:0]);
		end
		$display("test 1 done");
		// Floppy byte goes to ISA, no drive strobe
		xfer(32'h0000_03F7, 1'b0, 4'h7, 32'h0, 1'b1);
		check({fwd, nstrb[3:0]}, 5'h10);
		xfer(32'h0000_0377, 1'b1, 4'h7, 32'h0, 1'b1);
		check({fwd, nstrb[3:0]}, 5'h10);
		// Misses: upper bits, channel off, I/O space off
		xfer(32'h0001_01F7, 1'b0, 4'hE, 32'h0, 1'b0);
		chan_decode_en = 2'b01;
		xfer(32'h0000_0177, 1'b0, 4'hE, 32'h0, 1'b0);
		chan_decode_en = 2'b11;
		io_space_en = 1'b0;
		xfer(32'h0000_01F7, 1'b0, 4'hE, 32'h0, 1'b0);
		io_space_en = 1'b1;
		$display("test 2 done");
		// Drive select shadow, then drive 1 fast timing
		tim[1] = '{1'b1, 1'b0, 2'h3, 2'h1};
		isa_rcv16_en = 1'b1;
		wdat = 32'h0000_0010;
		xfer(32'h0000_01F6, 1'b1, 4'hE, 32'h0, 1'b1);
		check(shadow[0], 1'b1);
		check(last_wr[7:0], 8'h10);
		rd_value = xs();
		xfer(32'h0000_01F7, 1'b0, 4'hE, 32'h0000_00FF, 1'b1);
		check(widths[0], 11);
		check(rwait, 1'b1);
		rd_value = xs();
		xfer(32'h0000_01F0, 1'b0, 4'h0, 32'hFFFF_FFFF, 1'b1);
		check({nstrb[3:0], widths[0][3:0], widths[1][3:0]}, 12'h255);
		check(rwait, 1'b0);
		$display("test 3 done");
		// Drive 0 compatible data port, then late and masked ready
		wdat = 32'h0000_0000;
		xfer(32'h0000_01F6, 1'b1, 4'hE, 32'h0, 1'b1);
		check(shadow[0], 1'b0);
		xfer(32'h0000_01F0, 1'b0, 4'h0, 32'hFFFF_FFFF, 1'b1);
		check({nstrb[3:0], widths[0][3:0], widths[1][3:0]}, 12'h266);
		slow = 1'b1;
		xfer(32'h0000_01F7, 1'b0, 4'hE, 32'h0000_00FF, 1'b1);
		check(widths[0] >= 13 && widths[0] <= 40, 1'b1);
		tim[0].ready_mask = 1'b1;
		xfer(32'h0000_01F7, 1'b0, 4'hE, 32'h0000_00FF, 1'b1);
		check(widths[0], 11);
		$display("test 4 done");
		results();
	end
endmodule
